// ===== shared/ldc_defines.svh
// Constants and timing figures of the load driver control block
`ifndef LDC_DEFINES_SVH
`define LDC_DEFINES_SVH

// Core clock
`define LDC_CLK_MHZ          50
`define LDC_CLK_KHZ          50000

// Over-current filter of standard outputs and relay drivers
`define LDC_T_OC_US          60
`define LDC_OC_CYC           (`LDC_T_OC_US * `LDC_CLK_MHZ)
// Over-current blanking and auto-recovery pause of the strong output
`define LDC_T_STRONG_OC_US   120
`define LDC_T_RECOVER_US     400
`define LDC_STRONG_OC_CYC    (`LDC_T_STRONG_OC_US * `LDC_CLK_MHZ)
`define LDC_RECOVER_CYC      (`LDC_T_RECOVER_US * `LDC_CLK_MHZ)

// Slow timer: 0.5 s steps, on time 10 ms or 20 ms
`define LDC_T_SLOW_STEP_MS   500
`define LDC_T_SLOW_ON1_MS    10
`define LDC_T_SLOW_ON2_MS    20
`define LDC_SLOW_STEP_CYC    (`LDC_T_SLOW_STEP_MS * `LDC_CLK_KHZ)
// On times as fractions of one step, so a shortened step keeps the ratio
`define LDC_SLOW_ON1_DIV     (`LDC_T_SLOW_STEP_MS / `LDC_T_SLOW_ON1_MS)
`define LDC_SLOW_ON2_DIV     (`LDC_T_SLOW_STEP_MS / `LDC_T_SLOW_ON2_MS)

// Fast timer: 10 ms steps up to 200 ms, on time 100 us, 200 us or 1 ms
`define LDC_T_FAST_STEP_MS   10
`define LDC_FAST_MAX_SEL     5'h13
`define LDC_T_FAST_ON1_US    100
`define LDC_T_FAST_ON2_US    200
`define LDC_T_FAST_ON3_US    1000
`define LDC_FAST_STEP_CYC    (`LDC_T_FAST_STEP_MS * `LDC_CLK_KHZ)
`define LDC_T_FAST_STEP_US   (`LDC_T_FAST_STEP_MS * 1000)
`define LDC_FAST_ON1_DIV     (`LDC_T_FAST_STEP_US / `LDC_T_FAST_ON1_US)
`define LDC_FAST_ON2_DIV     (`LDC_T_FAST_STEP_US / `LDC_T_FAST_ON2_US)
`define LDC_FAST_ON3_DIV     (`LDC_T_FAST_STEP_US / `LDC_T_FAST_ON3_US)

// PWM prescaler steps per duty slot, one per base frequency
`define LDC_PWM_STEP0_CYC    3906
`define LDC_PWM_STEP1_CYC    1953
`define LDC_PWM_LAST_PHASE   7'h7F

// Channel layout of the sense and flag vectors
`define LDC_STRONG_IDX       4
`define LDC_FAILSAFE_IDX     2
`define LDC_FS_MASK          4'hB

`endif

// ===== shared/ldc_pkg.sv
// Types shared by the load driver control block
package ldc_pkg;

  typedef enum logic [2:0] {
    MODE_NORMAL  = 3'h0,
    MODE_STANDBY = 3'h1,
    MODE_SLEEP   = 3'h2,
    MODE_FORCED  = 3'h3,
    MODE_FLASH   = 3'h4
  } ldc_mode_t;

  typedef enum logic [1:0] {
    DRV_OFF      = 2'h0,
    DRV_ON       = 2'h1,
    DRV_PERIODIC = 2'h2,
    DRV_PWM      = 2'h3
  } ldc_drv_mode_t;

  // Settings of one output
  typedef struct packed {
    ldc_drv_mode_t mode;
    logic          timerFast;
    logic [6:0]    duty;
    logic          freqSel;
  } ldc_chan_cfg_t;

  // Whole settings word delivered at the end of a frame
  typedef struct packed {
    ldc_chan_cfg_t [4:0] hs;
    ldc_chan_cfg_t [1:0] ls;
    logic                lowOhm;
    logic                failSafeDisconnect;
    logic                strongOutAutoRecoverEn;
    logic                inhibitForceOff;
    logic [2:0]          slowPeriod;
    logic                slowOnLong;
    logic [4:0]          fastPeriod;
    logic [1:0]          fastOn;
  } ldc_cfg_t;

  typedef struct packed {
    logic [3:0] hsOut;
    logic       strongHighSideOut;
    logic [1:0] lowSideRelayDrivers;
    logic       inhibitOutput;
  } ldc_drv_t;

  typedef struct packed {
    logic [6:0] oc;
    logic [4:0] ul;
  } ldc_flags_t;

  typedef struct packed {
    logic [11:0] stepCnt;
    logic [6:0]  phase;
    logic        on;
  } ldc_pwm_state_t;

  typedef struct packed {
    logic [11:0]      s1;
    logic [11:0]      s2;
    logic [11:0]      s3;
    logic [11:0]      lvl;
    ldc_cfg_t         cfg;
    logic             cfgWritten;
    logic             shut;
    logic [6:0][14:0] ocCnt;
    ldc_flags_t       flags;
    logic             recovering;
    logic [14:0]      recovCnt;
    logic [27:0]      slowCnt;
    logic [27:0]      fastCnt;
    ldc_drv_t         drv;
  } ldc_state_t;

endpackage : ldc_pkg

// ===== hw/ldc_pwm_channel.sv
// One PWM channel: 128 duty slots per base period
`timescale 1ns/1ps
`default_nettype none
`include "ldc_defines.svh"

module ldc_pwm_channel #(
  parameter logic [11:0] STEP0_CYC = 12'(`LDC_PWM_STEP0_CYC),
  parameter logic [11:0] STEP1_CYC = 12'(`LDC_PWM_STEP1_CYC)
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Settings
  input  wire logic       freqSel,
  input  wire logic [6:0] duty,
  // Output
  output logic            pwmOn
);
  import ldc_pkg::*;

  ldc_pwm_state_t q;
  ldc_pwm_state_t n;
  logic [11:0]    stepLast;

  ////////////////////////////////////////////////////////////////////
  // Slot prescaler and phase; duty zero never matches, so stays off
  always_comb begin
    n = q;
    stepLast = (freqSel ? STEP1_CYC : STEP0_CYC) - 12'h001;
    if (q.stepCnt >= stepLast) begin
      n.stepCnt = 12'h000;
      n.phase   = q.phase + 7'h01;
    end else begin
      n.stepCnt = q.stepCnt + 12'h001;
    end
    n.on = (q.phase < duty);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign pwmOn = q.on;

  // Zero duty keeps the channel off
  a_pwm_zero_off: assert property (@(posedge clk) disable iff (rst)
    (duty == 7'h00) |=> !pwmOn)
    else $error("PWM on with zero duty");

endmodule : ldc_pwm_channel
`default_nettype wire

// ===== hw/ldc_load_driver_control.sv
// Load driver control: high-side, relay and inhibit drivers
`timescale 1ns/1ps
`default_nettype none
`include "ldc_defines.svh"

module ldc_load_driver_control #(
  parameter int unsigned STRONG_OC_CYC = `LDC_STRONG_OC_CYC,
  parameter int unsigned RECOVER_CYC   = `LDC_RECOVER_CYC,
  parameter int unsigned SLOW_STEP_CYC = `LDC_SLOW_STEP_CYC,
  // On times follow their step by default; overriding a step alone scales
  // the whole timer, which keeps on time below the period
  parameter int unsigned SLOW_ON1_CYC  = SLOW_STEP_CYC / `LDC_SLOW_ON1_DIV,
  parameter int unsigned SLOW_ON2_CYC  = SLOW_STEP_CYC / `LDC_SLOW_ON2_DIV,
  parameter int unsigned FAST_STEP_CYC = `LDC_FAST_STEP_CYC,
  parameter int unsigned FAST_ON1_CYC  = FAST_STEP_CYC / `LDC_FAST_ON1_DIV,
  parameter int unsigned FAST_ON2_CYC  = FAST_STEP_CYC / `LDC_FAST_ON2_DIV,
  parameter int unsigned FAST_ON3_CYC  = FAST_STEP_CYC / `LDC_FAST_ON3_DIV
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Device state
  input  wire ldc_pkg::ldc_mode_t devMode,
  input  wire logic              cyclicSenseActive,
  input  wire logic              failSafeSignal,
  input  wire logic              thermalShutdown2,
  // Settings from the serial port
  input  wire logic              spiFrameDone,
  input  wire ldc_pkg::ldc_cfg_t spiCfg,
  // Supervision
  input  wire logic              wdFail,
  input  wire logic              wdGoodTrigger,
  input  wire logic              mainRegulatorUnderVolt,
  // Comparator pins: over-current 6:0, under-load 4:0
  input  wire logic [6:0]        ocSense,
  input  wire logic [4:0]        ulSense,
  // Read-and-clear strobes
  input  wire ldc_pkg::ldc_flags_t flagClear,
  // Outputs
  output ldc_pkg::ldc_drv_t      drivers,
  output ldc_pkg::ldc_flags_t    flags,
  output logic                   hsSelectableLowOhm
);
  import ldc_pkg::*;

  ldc_state_t  q;
  ldc_state_t  n;
  logic [6:0]  pwmOn;
  logic        normalish;
  logic        pwmOk;
  logic        notForced;
  logic [27:0] slowPer;
  logic [27:0] fastPer;
  logic [27:0] slowOnCyc;
  logic [27:0] fastOnCyc;
  logic        slowWin;
  logic        fastWin;
  logic [4:0]  fastSel;
  logic [4:0]  hsWant;
  logic [1:0]  lsWant;
  logic [6:0]  drvOn;
  logic [6:0]  ocTrip;
  logic [14:0] ocLimit;

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Free-running period counter that wraps at the period length
  function automatic logic [27:0] nextCnt(input logic [27:0] cnt,
                                          input logic [27:0] per);
    nextCnt = (cnt >= per - 28'h1) ? 28'h0 : cnt + 28'h1;
  endfunction : nextCnt

  // Request of one high-side output from its settings
  function automatic logic hsRequest(input ldc_chan_cfg_t c,
                                     input logic pwm);
    logic r;
    r = 1'b0;
    unique case (c.mode)
      DRV_OFF:      r = 1'b0;
      DRV_ON:       r = notForced;
      DRV_PERIODIC: r = notForced && (c.timerFast ? fastWin : slowWin);
      DRV_PWM:      r = pwmOk && pwm;
    endcase
    return r;
  endfunction : hsRequest

  ////////////////////////////////////////////////////////////////////
  // PWM channels: 0-3 standard, 4 strong, 5-6 relay

  for (genvar i = 0; i < 7; i++) begin : g_pwm
    ldc_chan_cfg_t c;
    // Split by generate so no branch indexes outside its array
    if (i < 5) begin : g_hs
      assign c = q.cfg.hs[i];
    end else begin : g_ls
      assign c = q.cfg.ls[i - 5];
    end
    ldc_pwm_channel u_pwm (
      .clk     (clk),
      .rst     (rst),
      .freqSel (c.freqSel),
      .duty    (c.duty),
      .pwmOn   (pwmOn[i])
    );
  end

  ////////////////////////////////////////////////////////////////////
  // Mode qualifiers; flash mode drives loads like normal mode
  always_comb begin
    normalish = (devMode == MODE_NORMAL) || (devMode == MODE_FLASH);
    notForced = (devMode != MODE_FORCED);
    // protection and PWM share the same mode window
    pwmOk = normalish ||
            (((devMode == MODE_STANDBY) || (devMode == MODE_SLEEP)) &&
             cyclicSenseActive);
  end

  // Wake timer periods and on windows
  always_comb begin
    // slow timer steps of 0.5 s
    slowPer   = 28'((32'(q.cfg.slowPeriod) + 32'h1) * SLOW_STEP_CYC);
    slowOnCyc = q.cfg.slowOnLong ? 28'(SLOW_ON2_CYC) : 28'(SLOW_ON1_CYC);
    slowWin   = (q.slowCnt < slowOnCyc);
    // fast timer steps of 10 ms, clamped at 200 ms
    fastSel   = (q.cfg.fastPeriod > `LDC_FAST_MAX_SEL) ?
                `LDC_FAST_MAX_SEL : q.cfg.fastPeriod;
    fastPer   = 28'((32'(fastSel) + 32'h1) * FAST_STEP_CYC);
    unique case (q.cfg.fastOn)
      2'h0:    fastOnCyc = 28'(FAST_ON1_CYC);
      2'h1:    fastOnCyc = 28'(FAST_ON2_CYC);
      default: fastOnCyc = 28'(FAST_ON3_CYC);
    endcase
    fastWin = (q.fastCnt < fastOnCyc);
  end

  // Output requests before protection gating
  always_comb begin
    // strong output uses the same states
    for (int i = 0; i < 5; i++) begin
      hsWant[i] = hsRequest(q.cfg.hs[i], pwmOn[i]);
    end
    // relay drivers act in normal and flash modes only
    for (int j = 0; j < 2; j++) begin
      unique case (q.cfg.ls[j].mode)
        DRV_ON:  lsWant[j] = normalish;
        DRV_PWM: lsWant[j] = normalish && pwmOn[j + 5];
        default: lsWant[j] = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n = q;

    // Three-stage sampler; a level counts once stages two and three agree
    n.s1  = {ulSense, ocSense};
    n.s2  = q.s1;
    n.s3  = q.s2;
    n.lvl = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.lvl);

    // settings take effect when the frame completes
    if (spiFrameDone) begin
      n.cfg = spiCfg;
      // high-side outputs released only by a write in normal or flash mode
      if (normalish) begin
        n.cfgWritten = 1'b1;
      end
    end

    // fault shuts all drivers but inhibit and the undisconnected fail-safe level, good trigger restores
    if (wdFail || mainRegulatorUnderVolt) begin
      n.shut = 1'b1;
    end else if (wdGoodTrigger) begin
      n.shut = 1'b0;
    end

    // Wake timers run continuously
    n.slowCnt = nextCnt(q.slowCnt, slowPer);
    n.fastCnt = nextCnt(q.fastCnt, fastPer);

    // Over-current filters; a driver that is off cannot trip
    drvOn  = {q.drv.lowSideRelayDrivers, q.drv.strongHighSideOut, q.drv.hsOut};
    ocTrip = '0;
    for (int i = 0; i < 7; i++) begin
      ocLimit = (i == `LDC_STRONG_IDX) ? 15'(STRONG_OC_CYC) : 15'(`LDC_OC_CYC);
      // filters run only where protection is active
      if (drvOn[i] && q.lvl[i] && ((i < 5) ? pwmOk : normalish)) begin
        if (q.ocCnt[i] >= ocLimit - 15'h1) begin
          ocTrip[i]  = 1'b1;
          n.ocCnt[i] = 15'h0;
        end else begin
          n.ocCnt[i] = q.ocCnt[i] + 15'h1;
        end
      end else begin
        n.ocCnt[i] = 15'h0;
      end
    end

    if (q.recovering) begin
      if (q.recovCnt >= 15'(RECOVER_CYC) - 15'h1) begin
        n.recovering = 1'b0;
      end
      n.recovCnt = q.recovCnt + 15'h1;
    end
    if (ocTrip[`LDC_STRONG_IDX] && q.cfg.strongOutAutoRecoverEn) begin
      n.recovering = 1'b1;
      n.recovCnt   = 15'h0;
      ocTrip[`LDC_STRONG_IDX] = 1'b0;
    end

    // over-current flags; a set in the clear cycle wins
    n.flags.oc = (q.flags.oc & ~flagClear.oc) | ocTrip;

    // under-load flags only while the output is on
    for (int i = 0; i < 5; i++) begin
      if (drvOn[i] && pwmOk && q.lvl[i + 7]) begin
        n.flags.ul[i] = 1'b1;
      end else if (flagClear.ul[i]) begin
        n.flags.ul[i] = 1'b0;
      end
    end

    // Driver outputs, gated by shutdown and flags; high-side ones also by the write hold
    for (int i = 0; i < 4; i++) begin
      n.drv.hsOut[i] = hsWant[i] && q.cfgWritten && !q.shut &&
                       !q.flags.oc[i];
    end
    // third output shows the fail-safe level until disconnected
    if (!q.cfg.failSafeDisconnect) begin
      n.drv.hsOut[`LDC_FAILSAFE_IDX] = failSafeSignal && notForced;
    end
    n.drv.strongHighSideOut = hsWant[`LDC_STRONG_IDX] && q.cfgWritten &&
                              !q.shut && !q.recovering &&
                              !q.flags.oc[`LDC_STRONG_IDX];
    for (int j = 0; j < 2; j++) begin
      n.drv.lowSideRelayDrivers[j] = lsWant[j] && !q.shut &&
                                     !q.flags.oc[j + 5];
    end

    // inhibit follows normal and flash modes unless forced off
    // only the second thermal shutdown turns it off
    n.drv.inhibitOutput = normalish && !q.cfg.inhibitForceOff &&
                          !thermalShutdown2;

    if (devMode == MODE_FORCED) begin
      n.drv = '0;
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops

  // strength select, normal-ohmic after reset; also sets load threshold
  assign hsSelectableLowOhm = q.cfg.lowOhm;
  assign drivers            = q.drv;
  assign flags              = q.flags;

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_hold_until_write: assert property (
    !q.cfgWritten |=> ((q.drv.hsOut & `LDC_FS_MASK) == 4'h0))
    else $error("Standard output on before first write");

  a_cfg_apply_frame: assert property (
    spiFrameDone |=> (q.cfg == $past(spiCfg)))
    else $error("Settings not applied after frame");

  a_shut_all_off: assert property (
    q.shut |=> ((q.drv.hsOut & `LDC_FS_MASK) == 4'h0) &&
               !q.drv.strongHighSideOut && (q.drv.lowSideRelayDrivers == 2'h0))
    else $error("Driver on during shutdown");

  a_oc_flag_off: assert property (
    ((q.drv.hsOut & $past(q.flags.oc[3:0]) & `LDC_FS_MASK) == 4'h0))
    else $error("Standard output on with over-current flag");

  a_oc_flag_sticky: assert property (
    (q.flags.oc != 7'h00) && (flagClear.oc == 7'h00) |=>
      ((q.flags.oc & $past(q.flags.oc)) == $past(q.flags.oc)))
    else $error("Over-current flag dropped without clear");

  a_recover_off: assert property (
    $rose(q.recovering) |=> (!q.drv.strongHighSideOut && q.recovering) [*3])
    else $error("Strong output on during recovery pause");

  a_relay_normal_only: assert property (
    !normalish |=> (q.drv.lowSideRelayDrivers == 2'h0))
    else $error("Relay driver on outside normal mode");

  a_inhibit_force: assert property (
    q.cfg.inhibitForceOff |=> !q.drv.inhibitOutput)
    else $error("Inhibit on while forced off");

  a_forced_sleep_off: assert property (
    (devMode == MODE_FORCED) |=> (q.drv == '0))
    else $error("Driver on in forced sleep");

  c_strong_recover: cover property ($rose(q.recovering));
  c_oc_latch:       cover property ($rose(q.flags.oc[0]));
  c_shutdown:       cover property ($rose(q.shut) ##[1:20] $fell(q.shut));
  c_pwm_output:     cover property (q.cfg.hs[1].mode == DRV_PWM && $rose(q.drv.hsOut[1]));

endmodule : ldc_load_driver_control
`default_nettype wire

// ===== tb/ldc_load_model.sv
// Behavioural model of the loads hanging on the drivers
`timescale 1ns/1ps
`default_nettype none

module ldc_load_model (
  // Driver levels
  input  wire ldc_pkg::ldc_drv_t drivers,
  // Faults requested by the bench
  input  wire logic [6:0]        shortOn,
  input  wire logic [4:0]        openOn,
  // Comparator pins
  output logic [6:0]             ocSense,
  output logic [4:0]             ulSense
);
  import ldc_pkg::*;

  logic [6:0] onNow;

  ////////////////////////////////////////////////////////////////////////////
  // Current flows only through a closed switch, so a switched-off load
  // never shows a fault; this is what makes the retry cycle visible
  assign onNow   = {drivers.lowSideRelayDrivers, drivers.strongHighSideOut, drivers.hsOut};
  assign ocSense = shortOn & onNow;
  assign ulSense = openOn & onNow[4:0];
endmodule : ldc_load_model

`default_nettype wire

// ===== tb/test_load_driver_control.sv
// Self-checking bench of the load driver control block
`timescale 1ns/1ps
`default_nettype none

module test_load_driver_control;
  import ldc_pkg::*;

  logic       clk, rst, cyclicSenseActive, failSafeSignal, thermalShutdown2;
  logic       spiFrameDone, wdFail, wdGoodTrigger, mainRegulatorUnderVolt, hsSelectableLowOhm;
  ldc_mode_t  devMode;
  ldc_cfg_t   spiCfg, cfgV;
  ldc_flags_t flagClear, flags;
  ldc_drv_t   drivers;
  logic [6:0] ocSense, shortOn;
  logic [4:0] ulSense, openOn;
  int         err_total, n_compared, seed, n, m;
  int         onT[5] = '{20, 40, 10, 20, 100};
  int         chs[3] = '{0, 5, 4};
  int         lim[3] = '{3000, 3000, 20};

  ////////////////////////////////////////////////////////////////////////////
  // Short counts keep the timers and retry pause within a short run; on times scale with the steps
  ldc_load_driver_control #(.STRONG_OC_CYC(20), .RECOVER_CYC(40), .SLOW_STEP_CYC(1000), .FAST_STEP_CYC(1000))
  u_ldc_load_driver_control (.clk(clk), .rst(rst), .devMode(devMode), .cyclicSenseActive(cyclicSenseActive),
    .failSafeSignal(failSafeSignal), .thermalShutdown2(thermalShutdown2), .spiFrameDone(spiFrameDone),
    .spiCfg(spiCfg), .wdFail(wdFail), .wdGoodTrigger(wdGoodTrigger),
    .mainRegulatorUnderVolt(mainRegulatorUnderVolt), .ocSense(ocSense), .ulSense(ulSense),
    .flagClear(flagClear), .drivers(drivers), .flags(flags), .hsSelectableLowOhm(hsSelectableLowOhm));

  ldc_load_model u_ldc_load_model (.drivers(drivers), .shortOn(shortOn), .openOn(openOn),
    .ocSense(ocSense), .ulSense(ulSense));

  // Free-running core clock
  initial clk = 1'b0;
  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // Reporting and comparisons
  task automatic bad(input string msg);
    err_total++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask : bad

  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    n_compared++;
    if (got !== exp) bad(msg);
  endtask : chk_bit

  task automatic chk_cnt(input int got, input int lo, input int hi, input string msg);
    n_compared++;
    if (got < lo || got > hi) bad(msg);
  endtask : chk_cnt

  // Channel order follows the over-current flag vector
  function automatic logic drv_bit(input ldc_drv_t d, input int ch);
    logic [6:0] v;
    v = {d.lowSideRelayDrivers, d.strongHighSideOut, d.hsOut};
    return v[ch];
  endfunction : drv_bit

  // Whole periods in the window give an exact count whatever the phase
  function automatic int exp_on(input int win, input int per, input int onCyc);
    return (win / per) * onCyc;
  endfunction : exp_on

  ////////////////////////////////////////////////////////////////////////////
  // Bus-less helpers: frame delivery, bounded waits, counting
  task automatic apply();
    @(posedge clk);
    spiCfg       <= cfgV;
    spiFrameDone <= 1'b1;
    @(posedge clk);
    spiFrameDone <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : apply

  task automatic wait_flag(input int k, input int bound, output int c);
    c = 0;
    while (flags[k] !== 1'b1) begin
      if (c >= bound) begin
        bad("flag wait ran out");
        close_out();
      end
      @(negedge clk);
      c++;
    end
  endtask : wait_flag

  task automatic wait_drv(input int ch, input logic val, input int bound, output int c);
    c = 0;
    while (drv_bit(drivers, ch) !== val) begin
      if (c >= bound) begin
        bad("driver wait ran out");
        close_out();
      end
      @(negedge clk);
      c++;
    end
  endtask : wait_drv

  task automatic count_on(input int ch, input int win, output int c);
    c = 0;
    repeat (win) begin
      @(negedge clk);
      if (drv_bit(drivers, ch) === 1'b1) c++;
    end
  endtask : count_on

  task automatic clear_flag(input int k);
    @(posedge clk);
    flagClear[k] <= 1'b1;
    @(posedge clk);
    flagClear    <= '0;
    repeat (3) @(negedge clk);
  endtask : clear_flag

  task automatic pulse_wd(input logic fail);
    @(posedge clk);
    if (fail) wdFail <= 1'b1;
    else wdGoodTrigger <= 1'b1;
    @(posedge clk);
    wdFail        <= 1'b0;
    wdGoodTrigger <= 1'b0;
    repeat (2) @(negedge clk);
  endtask : pulse_wd

  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    bad("run did not finish");
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 41183;
    err_total = 0;
    n_compared = 0;
    rst = 1'b1;
    devMode = MODE_NORMAL;
    {cyclicSenseActive, failSafeSignal, thermalShutdown2, spiFrameDone} = '0;
    {wdFail, wdGoodTrigger, mainRegulatorUnderVolt} = '0;
    spiCfg = '0;
    cfgV = '0;
    flagClear = '0;
    shortOn = '0;
    openOn = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    chk_bit(drivers.hsOut[0] | drivers.hsOut[1] | drivers.hsOut[3], 1'b0, "outputs on before write");
    chk_bit(hsSelectableLowOhm, 1'b0, "strength default");
    chk_bit(drivers.inhibitOutput, 1'b1, "inhibit off in normal");
    // Random fail-safe levels must reach the third output
    repeat (20) begin
      @(posedge clk);
      failSafeSignal <= 1'($random(seed));
      repeat (2) @(negedge clk);
      chk_bit(drivers.hsOut[2], failSafeSignal, "fail-safe not followed");
    end
    cfgV.hs[0].mode = DRV_ON;
    cfgV.hs[4].mode = DRV_ON;
    cfgV.ls[0].mode = DRV_ON;
    cfgV.ls[1].mode = DRV_PWM;
    cfgV.hs[3].mode = DRV_PERIODIC;
    cfgV.lowOhm = 1'b1;
    apply();
    chk_bit(drivers.hsOut[0], 1'b1, "setting not applied");
    chk_bit(hsSelectableLowOhm, 1'b1, "strength not applied");
    chk_bit(drivers.strongHighSideOut, 1'b1, "strong not on");
    chk_bit(drivers.lowSideRelayDrivers[0], 1'b1, "relay not on");
    count_on(6, 300, n);
    chk_cnt(n, 0, 0, "zero duty drives");
    // Slow and fast periodic activation, every on-time choice
    for (int i = 0; i < 5; i++) begin
      cfgV.hs[3].timerFast = (i > 1);
      cfgV.slowOnLong = (i == 1);
      cfgV.fastOn = 2'(i - 2);
      apply();
      count_on(3, 2000, n);
      m = exp_on(2000, 1000, onT[i]);
      chk_cnt(n, m, m, "periodic on time");
    end
    cfgV.hs[1].mode = DRV_PWM;
    cfgV.hs[1].duty = 7'h7F;
    cfgV.hs[1].freqSel = 1'b1;
    apply();
    count_on(1, 4000, n);
    chk_cnt(n, 2047, 4000, "full duty pwm");
    @(posedge clk);
    failSafeSignal <= 1'b1;
    cfgV.failSafeDisconnect = 1'b1;
    apply();
    chk_bit(drivers.hsOut[2], 1'b0, "fail-safe still drives");
    // Missing load flags but keeps the output on
    @(posedge clk);
    openOn[0] <= 1'b1;
    wait_flag(0, 12, n);
    chk_bit(drivers.hsOut[0], 1'b1, "under-load disabled output");
    @(posedge clk);
    openOn <= '0;
    // Let the filtered level fall first, else the set beats the clear
    repeat (6) @(negedge clk);
    clear_flag(0);
    chk_bit(flags.ul[0], 1'b0, "under-load flag stuck");
    // Over-current on standard, relay and strong outputs
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      shortOn[chs[i]] <= 1'b1;
      wait_flag(5 + chs[i], 4000, n);
      chk_cnt(n, lim[i], lim[i] + 12, "over-current filter time");
      repeat (2) @(negedge clk);
      @(posedge clk);
      shortOn <= '0;
      repeat (20) @(negedge clk);
      chk_bit(drv_bit(drivers, chs[i]), 1'b0, "driver back before clear");
      clear_flag(5 + chs[i]);
      chk_bit(drv_bit(drivers, chs[i]), 1'b1, "driver not back after clear");
    end
    cfgV.strongOutAutoRecoverEn = 1'b1;
    apply();
    @(posedge clk);
    shortOn[4] <= 1'b1;
    wait_drv(4, 1'b0, 60, n);
    wait_drv(4, 1'b1, 100, m);
    chk_cnt(m, 39, 42, "retry pause");
    chk_bit(flags.oc[4], 1'b0, "flag set under auto-recovery");
    @(posedge clk);
    shortOn <= '0;
    // Supervision faults drop the drivers until a good trigger
    pulse_wd(1'b1);
    chk_bit(drivers.hsOut[0] | drivers.lowSideRelayDrivers[0], 1'b0, "drivers after watchdog fail");
    repeat (5) @(negedge clk);
    pulse_wd(1'b0);
    chk_bit(drivers.hsOut[0], 1'b1, "drivers not restored");
    @(posedge clk);
    mainRegulatorUnderVolt <= 1'b1;
    repeat (3) @(negedge clk);
    chk_bit(drivers.strongHighSideOut, 1'b0, "drivers on under-voltage");
    @(posedge clk);
    mainRegulatorUnderVolt <= 1'b0;
    pulse_wd(1'b0);
    chk_bit(drivers.strongHighSideOut, 1'b1, "strong not restored");
    cfgV.inhibitForceOff = 1'b1;
    apply();
    chk_bit(drivers.inhibitOutput, 1'b0, "inhibit not forced off");
    cfgV.inhibitForceOff = 1'b0;
    apply();
    @(posedge clk);
    thermalShutdown2 <= 1'b1;
    repeat (2) @(negedge clk);
    chk_bit(drivers.inhibitOutput, 1'b0, "inhibit on in shutdown");
    @(posedge clk);
    thermalShutdown2 <= 1'b0;
    devMode <= MODE_FLASH;
    repeat (2) @(negedge clk);
    chk_bit(drivers.inhibitOutput, 1'b1, "inhibit off in flash");
    @(posedge clk);
    devMode <= MODE_STANDBY;
    repeat (2) @(negedge clk);
    chk_bit(drivers.hsOut[0], 1'b1, "always-on dropped in standby");
    chk_bit(drivers.lowSideRelayDrivers[0], 1'b0, "relay on in standby");
    chk_bit(drivers.inhibitOutput, 1'b0, "inhibit on in standby");
    chk_bit(drivers.hsOut[1], 1'b0, "pwm on without cyclic sense");
    @(posedge clk);
    devMode <= MODE_SLEEP;
    cyclicSenseActive <= 1'b1;
    repeat (2) @(negedge clk);
    chk_bit(drivers.hsOut[1], 1'b1, "pwm off with cyclic sense");
    @(posedge clk);
    devMode <= MODE_FORCED;
    repeat (2) @(negedge clk);
    chk_bit(|drivers, 1'b0, "driver on in forced sleep");
    close_out();
  end
endmodule : test_load_driver_control

`default_nettype wire
